// File: dss_sequencer.sv
// Dual-slope conversion sequencer: phase control, rundown counting and display drive.
`timescale 1ns/1ps
module dss_sequencer #(
    parameter int OSC_DIV    = dss_pkg::OSC_DIV,
    parameter int PLANE_DIV  = dss_pkg::PLANE_DIV,
    parameter int CYC_COUNTS = dss_pkg::CYC_COUNTS,
    parameter int ACC_COUNTS = dss_pkg::ACC_COUNTS,
    parameter int RUN_MAX    = dss_pkg::RUN_MAX
) (
    // Clock, reset and enable.
    input  wire logic                      sys_clk,
    input  wire logic                      resetn,
    input  wire logic                      ce,
    // Analog side, asynchronous inputs.
    input  wire logic                      comparator_pos,
    input  wire logic                      display_check,
    // Analog switch controls.
    output logic                           input_short,
    output logic                           ref_charge,
    output logic                           offset_loop,
    output logic                           input_connect,
    output logic                           neg_to_midpoint,
    output logic                           ref_forward,
    output logic                           ref_reverse,
    output dss_pkg::dss_phase_t            phase,
    // Reading and display.
    output logic [dss_pkg::BCD_W-1:0]      reading,
    output logic                           reading_neg,
    output logic                           over_range,
    output logic                           backplane_drive,
    output logic [dss_pkg::SEG_W-1:0]      seg_drive
);
    localparam int W = dss_pkg::CNT_W;
    localparam int BW = dss_pkg::BCD_W;
    localparam int SW = dss_pkg::SEG_W;
    localparam logic [W-1:0] ACC_LAST  = W'(ACC_COUNTS - 1);
    localparam logic [W-1:0] RUN_LAST  = W'(ACC_COUNTS + RUN_MAX - 1);
    localparam logic [W-1:0] CYC_LAST  = W'(CYC_COUNTS - 1);
    localparam logic [W-1:0] RESET_CYC = W'(ACC_COUNTS + RUN_MAX);

    logic                rst_q1;
    logic                rst_n;
    logic                cmp_q1;
    logic                cmp_s;
    logic                chk_q1;
    logic                chk_s;
    logic                count_tick;
    logic                plane_tick;
    logic                tick_en;
    logic                zero_hit;
    dss_pkg::dss_phase_t state_reg;
    dss_pkg::dss_phase_t state_next;
    logic [W-1:0]        cyc_reg;
    logic [W-1:0]        cyc_next;
    logic                pol_reg;
    logic [BW-1:0]       run_cnt_reg;
    logic                plane_next;
    logic [20:0]         dig_on;
    logic [SW-1:0]       seg_on;

    function automatic logic [BW-1:0] bcd_inc(input logic [BW-1:0] v);
        logic [BW-1:0] r;
        logic          c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < BW / 4; i++) begin
            if (c) begin
                if (r[4*i+:4] == 4'h9) begin
                    r[4*i+:4] = 4'h0;
                end else begin
                    r[4*i+:4] = r[4*i+:4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // Segment order is g f e d c b a.
    function automatic logic [6:0] seven(input logic [3:0] d);
        case (d)
            4'h0: seven = 7'h3f;
            4'h1: seven = 7'h06;
            4'h2: seven = 7'h5b;
            4'h3: seven = 7'h4f;
            4'h4: seven = 7'h66;
            4'h5: seven = 7'h6d;
            4'h6: seven = 7'h7d;
            4'h7: seven = 7'h07;
            4'h8: seven = 7'h7f;
            4'h9: seven = 7'h6f;
            default: seven = 7'h00;
        endcase
    endfunction

    // The reset release is retimed so that no flop leaves reset on a different edge.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_q1 <= 1'b0;
            cmp_s  <= 1'b0;
            chk_q1 <= 1'b0;
            chk_s  <= 1'b0;
        end else if (ce) begin
            cmp_q1 <= comparator_pos;
            cmp_s  <= cmp_q1;
            chk_q1 <= display_check;
            chk_s  <= chk_q1;
        end
    end

    dss_prescale #(
        .OSC_DIV (OSC_DIV),
        .PLANE_DIV (PLANE_DIV)
    ) u_prescale (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .count_tick (count_tick),
        .plane_tick (plane_tick)
    );

    assign tick_en  = count_tick & ce;
    assign zero_hit = (cmp_s != pol_reg);

    // The cycle counter spans accumulate, rundown and null, so null absorbs what rundown leaves.
    always_comb begin
        state_next = state_reg;
        cyc_next   = cyc_reg;
        if (tick_en) begin
            cyc_next = cyc_reg + W'(1);
            case (state_reg)
                dss_pkg::PH_ACC: begin
                    if (cyc_reg == ACC_LAST) state_next = dss_pkg::PH_RUN;
                end
                dss_pkg::PH_RUN: begin
                    if (zero_hit || cyc_reg == RUN_LAST) state_next = dss_pkg::PH_NULL;
                end
                dss_pkg::PH_NULL: begin
                    if (cyc_reg == CYC_LAST) begin
                        state_next = dss_pkg::PH_ACC;
                        cyc_next   = '0;
                    end
                end
                default: state_next = dss_pkg::PH_NULL;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= dss_pkg::PH_NULL;
            cyc_reg   <= RESET_CYC;
        end else if (ce) begin
            state_reg <= state_next;
            cyc_reg   <= cyc_next;
        end
    end

    // Switch controls follow the next phase so they change with the phase itself.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            input_short     <= 1'b1;
            ref_charge      <= 1'b1;
            offset_loop     <= 1'b1;
            input_connect   <= 1'b0;
            neg_to_midpoint <= 1'b0;
            ref_forward     <= 1'b0;
            ref_reverse     <= 1'b0;
            phase           <= dss_pkg::PH_NULL;
        end else if (ce) begin
            input_short     <= (state_next == dss_pkg::PH_NULL);
            ref_charge      <= (state_next == dss_pkg::PH_NULL);
            offset_loop     <= (state_next == dss_pkg::PH_NULL);
            input_connect   <= (state_next == dss_pkg::PH_ACC);
            neg_to_midpoint <= (state_next == dss_pkg::PH_RUN);
            ref_forward     <= (state_next == dss_pkg::PH_RUN) && !((state_reg == dss_pkg::PH_ACC) ? cmp_s : pol_reg);
            ref_reverse     <= (state_next == dss_pkg::PH_RUN) && ((state_reg == dss_pkg::PH_ACC) ? cmp_s : pol_reg);
            phase           <= state_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pol_reg <= 1'b0;
        end else if (ce && state_reg == dss_pkg::PH_ACC && state_next == dss_pkg::PH_RUN) begin
            pol_reg <= cmp_s;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_cnt_reg <= '0;
        end else if (ce && state_next == dss_pkg::PH_RUN) begin
            if (state_reg == dss_pkg::PH_ACC) begin
                run_cnt_reg <= '0;
            end else if (tick_en) begin
                run_cnt_reg <= bcd_inc(run_cnt_reg);
            end
        end
    end

    // The display only moves at rundown end, so digits never show a count in progress.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reading     <= '0;
            reading_neg <= 1'b0;
            over_range  <= 1'b0;
        end else if (ce && state_reg == dss_pkg::PH_RUN && state_next == dss_pkg::PH_NULL) begin
            reading     <= run_cnt_reg;
            reading_neg <= !pol_reg;
            over_range  <= !zero_hit;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_digit
            assign dig_on[7*gi+:7] = seven(reading[4*gi+:4]);
        end
    endgenerate

    // Over range shows a lone leading one with the lower digits blank.
    assign seg_on = over_range ? {reading_neg, 2'b11, 21'h0}
                               : {reading_neg, {2{reading[15:12] != 4'h0}}, dig_on};
    // A held backplane under display check puts a steady level on the glass; users must not leave it on.
    assign plane_next = chk_s ? 1'b0 : (plane_tick ? !backplane_drive : backplane_drive);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            backplane_drive <= 1'b0;
            seg_drive       <= '0;
        end else if (ce) begin
            backplane_drive <= plane_next;
            seg_drive       <= chk_s ? {SW{1'b1}} : (seg_on ^ {SW{plane_next}});
        end
    end

    // Helper counters watched only by the checks below.
    logic [W-1:0] ph_ticks;
    logic [W-1:0] cyc_ticks;
    logic         seen_acc;
    logic [9:0]   plane_gap;
    logic         plane_clean;
    // The first edge after reset or a display check has an arbitrary gap, so only later edges are timed.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_ticks    <= '0;
            cyc_ticks   <= '0;
            seen_acc    <= 1'b0;
            plane_gap   <= '0;
            plane_clean <= 1'b0;
        end else if (ce) begin
            ph_ticks    <= (state_next != state_reg) ? '0 : ph_ticks + W'(tick_en);
            cyc_ticks   <= (state_next == dss_pkg::PH_ACC && state_reg != dss_pkg::PH_ACC) ? '0
                           : cyc_ticks + W'(tick_en);
            seen_acc    <= seen_acc | (state_reg == dss_pkg::PH_ACC);
            plane_gap   <= (backplane_drive != plane_next) ? 10'h0 : plane_gap + 10'h1;
            plane_clean <= !chk_s && (plane_clean || backplane_drive != plane_next);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    cycle_len_a: assert property (state_reg == dss_pkg::PH_NULL && state_next == dss_pkg::PH_ACC && seen_acc
        |-> cyc_ticks == W'(CYC_COUNTS - 1)) else $error("cycle length wrong");
    acc_len_a: assert property (state_reg == dss_pkg::PH_ACC && state_next != dss_pkg::PH_ACC
        |-> ph_ticks == W'(ACC_COUNTS - 1)) else $error("accumulate length wrong");
    phase_order_a: assert property (state_reg != state_next |-> state_next ==
        ((state_reg == dss_pkg::PH_NULL) ? dss_pkg::PH_ACC : (state_reg == dss_pkg::PH_ACC) ? dss_pkg::PH_RUN
        : dss_pkg::PH_NULL)) else $error("phase order wrong");
    null_switch_a: assert property (phase == dss_pkg::PH_NULL
        |-> input_short && ref_charge && offset_loop && !input_connect) else $error("null switches wrong");
    acc_switch_a: assert property ($rose(phase == dss_pkg::PH_ACC)
        |-> input_connect && !offset_loop && !input_short) else $error("accumulate switches wrong");
    pol_store_a: assert property (ce && state_reg == dss_pkg::PH_ACC && state_next == dss_pkg::PH_RUN
        |=> pol_reg == $past(cmp_s)) else $error("polarity not stored");
    rundown_ref_a: assert property (phase == dss_pkg::PH_RUN
        |-> neg_to_midpoint && ref_reverse == pol_reg && ref_forward != ref_reverse) else $error("rundown ref");
    reading_a: assert property (ce && state_reg == dss_pkg::PH_RUN && state_next == dss_pkg::PH_NULL
        |=> reading == $past(run_cnt_reg)) else $error("reading not latched");
    check_seg_a: assert property (chk_s && ce |=> seg_drive == {SW{1'b1}}) else $error("check not lit");
    check_dc_a: assert property (chk_s && ce |=> !backplane_drive ##1 $stable(seg_drive) || !chk_s)
        else $error("check not steady");
    null_len_a: assert property (state_reg == dss_pkg::PH_NULL && state_next == dss_pkg::PH_ACC && seen_acc
        |-> ph_ticks >= W'(CYC_COUNTS - ACC_COUNTS - RUN_MAX - 1)) else $error("null too short");
    plane_half_a: assert property (!chk_s && ce && plane_clean && backplane_drive != plane_next
        |-> plane_gap == 10'(PLANE_DIV / 2 - 1)) else $error("backplane period wrong");
    latch_hold_a: assert property (!(state_reg == dss_pkg::PH_RUN && state_next == dss_pkg::PH_NULL)
        |=> $stable(reading)) else $error("reading moved");
    over_flag_a: assert property (ce && tick_en && state_reg == dss_pkg::PH_RUN && cyc_reg == RUN_LAST && !zero_hit
        |=> over_range && phase == dss_pkg::PH_NULL) else $error("over range missed");

    run_cross_c: cover property (state_reg == dss_pkg::PH_RUN && state_next == dss_pkg::PH_NULL && zero_hit);
    run_over_c: cover property (state_reg == dss_pkg::PH_RUN && state_next == dss_pkg::PH_NULL && !zero_hit);
    neg_read_c: cover property (reading_neg && !over_range);
    check_on_c: cover property (chk_s ##1 seg_drive == {SW{1'b1}});
endmodule

// File: dss_prescale.sv
// Shared constants of the conversion sequencer and its oscillator prescaler.
// What this block does
// - Measurement cycle lasts 4000 counts, 16000 oscillator periods.
// - Input accumulate phase lasts exactly 1000 counts.
// - Phases repeat: offset null, accumulate, rundown.
// - Null phase shorts inputs, charges reference, closes loop.
// - Accumulate opens loop and connects input pins.
// - Polarity stored at the end of accumulate.
// - Rundown grounds negative input, reference opposes polarity.
// - Rundown counts until the comparator sees zero.
// - Display check lights every segment and sign.
// - Display check drives segments with a steady level.
// - Rundown takes 1 to 2000 counts, null the rest.
// - Backplane square wave at oscillator over 800.
package dss_pkg;
    localparam int OSC_DIV    = 4;
    localparam int PLANE_DIV  = 800;
    localparam int CYC_COUNTS = 4000;
    localparam int ACC_COUNTS = 1000;
    localparam int RUN_MAX    = 2000;
    localparam int NULL_MIN   = CYC_COUNTS - ACC_COUNTS - RUN_MAX;
    localparam int CNT_W      = 12;
    localparam int BCD_W      = 16;
    localparam int SEG_W      = 24;
    typedef enum logic [2:0] {
        PH_NULL = 3'h1,
        PH_ACC  = 3'h2,
        PH_RUN  = 3'h4
    } dss_phase_t;
endpackage

`timescale 1ns/1ps
module dss_prescale #(
    parameter int OSC_DIV   = dss_pkg::OSC_DIV,
    parameter int PLANE_DIV = dss_pkg::PLANE_DIV
) (
    // Clock, reset and enable.
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Strobes, each high for one enabled cycle.
    output logic      count_tick,
    output logic      plane_tick
);
    localparam logic [9:0] DIV_LAST   = 10'(OSC_DIV - 1);
    localparam logic [9:0] PLANE_LAST = 10'(PLANE_DIV / 2 - 1);

    logic [9:0] div_reg;
    logic [9:0] plane_cnt_reg;

    // The counting clock is the oscillator divided by four.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg    <= 10'h0;
            count_tick <= 1'b0;
        end else if (ce) begin
            div_reg    <= (div_reg == DIV_LAST) ? 10'h0 : div_reg + 10'h1;
            count_tick <= (div_reg == DIV_LAST);
        end
    end

    // Toggling every half period gives a square wave at the oscillator over 800.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            plane_cnt_reg <= 10'h0;
            plane_tick    <= 1'b0;
        end else if (ce) begin
            plane_cnt_reg <= (plane_cnt_reg == PLANE_LAST) ? 10'h0 : plane_cnt_reg + 10'h1;
            plane_tick    <= (plane_cnt_reg == PLANE_LAST);
        end
    end
endmodule

// File: dss_analog_model.sv
// Model of the analog input network: the integrator sign as the comparator reports it.
`timescale 1ns/1ps
module dss_analog_model (
    // Clock and phase from the sequencer.
    input  wire logic                sys_clk,
    input  wire dss_pkg::dss_phase_t phase,
    // Scenario settings: integrated sign and rundown length in counts.
    input  wire logic                integ_pos,
    input  wire logic [7:0]          run_counts,
    // Comparator output.
    output logic                     comparator_pos
);
    int run_cyc;
    initial comparator_pos = 1'b0;
    initial run_cyc = 0;
    always @(negedge sys_clk) begin
        if (phase == dss_pkg::PH_RUN) begin
            run_cyc = run_cyc + 1;
            // The crossing lands mid-way between two count ticks, clear of the synchroniser.
            if (run_cyc >= dss_pkg::OSC_DIV * int'(run_counts) - 1) begin
                comparator_pos <= !integ_pos;
            end else begin
                comparator_pos <= integ_pos;
            end
        end else if (phase == dss_pkg::PH_ACC) begin
            run_cyc = 0;
            comparator_pos <= integ_pos;
        end else begin
            run_cyc = 0;
            // Ignored while nulling, so it wanders rather than holding a kind value.
            comparator_pos <= !comparator_pos;
        end
    end
endmodule

// File: tb_dss_sequencer.sv
// Self-checking testbench of the conversion sequencer with shortened counts.
`timescale 1ns/1ps
module tb_dss_sequencer;
    localparam int OSC   = 4;
    localparam int PLANE = 8;
    localparam int CYC   = 40;
    localparam int ACC   = 10;
    localparam int RUN   = 20;
    localparam int LIMIT = 8000;
    logic                sys_clk;
    logic                resetn;
    logic                ce;
    logic                comparator_pos;
    logic                display_check;
    logic                input_short;
    logic                ref_charge;
    logic                offset_loop;
    logic                input_connect;
    logic                neg_to_midpoint;
    logic                ref_forward;
    logic                ref_reverse;
    dss_pkg::dss_phase_t phase;
    logic [15:0]         reading;
    logic                reading_neg;
    logic                over_range;
    logic                backplane_drive;
    logic [23:0]         seg_drive;
    logic                integ_pos;
    logic [7:0]          run_counts;
    int                  err_count;
    int                  check_count;
    int                  cyc_count;

    dss_sequencer #(.OSC_DIV(OSC), .PLANE_DIV(PLANE), .CYC_COUNTS(CYC), .ACC_COUNTS(ACC), .RUN_MAX(RUN)) u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .comparator_pos(comparator_pos),
        .display_check(display_check), .input_short(input_short), .ref_charge(ref_charge),
        .offset_loop(offset_loop), .input_connect(input_connect), .neg_to_midpoint(neg_to_midpoint),
        .ref_forward(ref_forward), .ref_reverse(ref_reverse), .phase(phase), .reading(reading),
        .reading_neg(reading_neg), .over_range(over_range), .backplane_drive(backplane_drive),
        .seg_drive(seg_drive)
    );
    dss_analog_model u_model (
        .sys_clk(sys_clk), .phase(phase), .integ_pos(integ_pos), .run_counts(run_counts),
        .comparator_pos(comparator_pos)
    );

    task automatic summarize();
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_phase(input dss_pkg::dss_phase_t p);
        int n;
        n = 0;
        while (phase !== p && n < 20000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    // Counts clock cycles spent in one phase and notes whether the reading moved meanwhile.
    task automatic span(input dss_pkg::dss_phase_t p, output int len, output logic moved);
        logic [15:0] start;
        start = reading;
        moved = 1'b0;
        len = 0;
        while (phase === p && len < 20000) begin
            @(negedge sys_clk);
            if (phase === p && reading !== start) moved = 1'b1;
            len++;
        end
    endtask

    function automatic logic [15:0] to_bcd(input int v);
        to_bcd = {4'h0, 4'(v / 100), 4'((v / 10) % 10), 4'(v % 10)};
    endfunction

    task automatic conv_case(input logic pos, input int n);
        int acc_len;
        int run_len;
        int null_len;
        logic moved;
        integ_pos = pos;
        run_counts = n[7:0];
        wait_phase(dss_pkg::PH_NULL);
        wait_phase(dss_pkg::PH_ACC);
        chk({input_short, ref_charge, offset_loop, input_connect, neg_to_midpoint}, 5'b00010);
        span(dss_pkg::PH_ACC, acc_len, moved);
        chk(acc_len, ACC * OSC);
        chk(phase, dss_pkg::PH_RUN);
        chk({input_short, input_connect, neg_to_midpoint, ref_forward, ref_reverse}, {3'b001, !pos, pos});
        span(dss_pkg::PH_RUN, run_len, moved);
        chk(moved, 1'b0);
        if (n < RUN) chk(run_len, OSC * (n + 1));
        chk(run_len <= OSC * (RUN + 1), 1'b1);
        chk(phase, dss_pkg::PH_NULL);
        chk({input_short, ref_charge, offset_loop, input_connect, neg_to_midpoint}, 5'b11100);
        // The tick that ends rundown is not counted, so a full-length rundown leaves one below the limit.
        chk(reading, to_bcd((n < RUN) ? n : RUN - 1));
        chk(reading_neg, !pos);
        chk(over_range, n >= RUN);
        span(dss_pkg::PH_NULL, null_len, moved);
        chk(acc_len + run_len + null_len, CYC * OSC);
    endtask

    task automatic lamp_case();
        int n;
        logic b;
        display_check = 1'b1;
        repeat (4) @(negedge sys_clk);
        repeat (12) begin
            chk({backplane_drive, seg_drive}, {1'b0, 24'hffffff});
            @(negedge sys_clk);
        end
        display_check = 1'b0;
        repeat (4) @(negedge sys_clk);
        b = backplane_drive;
        n = 0;
        while (backplane_drive === b && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        b = backplane_drive;
        n = 0;
        while (backplane_drive === b && n < 100) begin
            if (n == 2) chk(seg_drive[23], reading_neg ^ backplane_drive);
            // The last conversion read minus nineteen, so the digits show sign, blank, 0, 1, 9.
            if (n == 2) chk(seg_drive, {1'b1, 2'b00, 7'h3f, 7'h06, 7'h6f} ^ {24{backplane_drive}});
            @(negedge sys_clk);
            n++;
        end
        chk(n, PLANE / 2);
    endtask

    // With the enable low nothing may advance, so the cycle length counts enabled cycles only.
    task automatic hold_case();
        logic [3:0] snap;
        ce = 1'b0;
        repeat (3) @(negedge sys_clk);
        snap = {phase, backplane_drive};
        repeat (20) begin
            @(negedge sys_clk);
            chk({phase, backplane_drive}, snap);
        end
        ce = 1'b1;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc_count++;
        if (cyc_count >= LIMIT) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        display_check = 1'b0;
        integ_pos = 1'b1;
        run_counts = 8'h05;
        err_count = 0;
        check_count = 0;
        cyc_count = 0;
        repeat (10) @(negedge sys_clk);
        chk({input_short, ref_charge, offset_loop, input_connect, neg_to_midpoint, ref_forward, ref_reverse,
             phase, reading, over_range}, {3'b111, 4'h0, 3'h1, 16'h0000, 1'b0});
        resetn = 1'b1;
        conv_case(1'b1, 7);
        conv_case(1'b0, 13);
        conv_case(1'b1, 0);
        conv_case(1'b0, RUN - 1);
        lamp_case();
        hold_case();
        conv_case(1'b1, RUN + 5);
        conv_case(1'b0, 3);
        summarize();
    end
endmodule
